// ===== rtl/line_mode_ctrl.v
`include "line_mode_ctrl_map.vh"

// mode control and supervision of the line interface
module line_mode_ctrl
(
  input  wire        MCLK,
  input  wire        RESETN,
  // mode control pins
  input  wire        POWERDOWN_N,
  input  wire        CTRL_BIT0_TTX_ENABLE,
  input  wire        CTRL_BIT1_ACTIVE_SELECT,
  input  wire        CTRL_BIT2_POLARITY,
  input  wire        GAIN_SELECT,
  input  wire        METERING_TONE_CLOCK,
  // analog supervision flags
  input  wire        THERMAL_OVERLOAD,
  input  wire        OFF_HOOK_SENSE,
  input  wire        RING_TRIP_SENSE,
  // open-drain loop detect pin
  input  wire        LOOP_DETECT_N_I,
  output reg         LOOP_DETECT_N_O,
  output reg         LOOP_DETECT_N_OE,
  // line stage controls
  output reg         LINE_HIGH_Z,
  output reg         DETECT_ENABLE,
  output reg         HIGH_IMPEDANCE_FEED,
  output reg         DC_FEED_ENABLE,
  output reg         TX_ENABLE,
  output reg         FEEDBACK_ENABLE,
  output reg         VOLTAGE_BUFFER_MODE,
  output reg         RX_GAIN_PLUS6,
  output reg         TX_GAIN_MINUS12,
  output reg         ZSCALE_X25,
  output reg  [7:0]  POLARITY_LEVEL,
  output reg         METERING_ENABLE,
  output reg         SHAPED_METERING_SQUARE,
  output reg         INTERRUPT,
  // AXI4-Lite slave
  input  wire [5:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output reg         S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output reg         S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [5:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output reg         S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY
);

  // reset divider worked out as an integer, then cut to the register width
  localparam integer RAMP_DIV_RST_I = `RAMP_DIV_RST;
  localparam [15:0]  RAMP_DIV_RST_C = RAMP_DIV_RST_I[15:0];

  // pin decode of the operating mode, one-hot result
  function [3:0] mode_decode;
    input down_n;
    input b0;
    input b1;
    begin
      if (!down_n)
        mode_decode = `MODE_DOWN;
      else if (b1)
        mode_decode = `MODE_ACT;
      else if (b0)
        mode_decode = `MODE_RING;
      else
        mode_decode = `MODE_HIZ;
    end
  endfunction

  // true for an offset that holds a register
  function is_mapped;
    input [5:0] addr;
    begin
      case (addr)
        `OFF_STATUS, `OFF_INT_STATUS, `OFF_INT_ENABLE,
        `OFF_INT_CLEAR, `OFF_RAMP_CTRL: is_mapped = 1'b1;
        default:                        is_mapped = 1'b0;
      endcase
    end
  endfunction

  reg  [3:0]         mode;           // applied mode, one-hot
  reg  [3:0]         next_mode;
  wire [3:0]         pin_mode;       // mode the pins ask for
  reg                overload;       // registered overload flag
  reg                detect;         // registered detect condition
  reg                next_detect;
  reg  [`EV_W-1:0]   int_status;     // sticky events
  reg  [`EV_W-1:0]   int_enable;     // event mask
  reg  [`EV_W-1:0]   int_clear;      // one-cycle clear pulse
  reg  [`EV_W-1:0]   events;
  reg  [`EV_W-1:0]   next_int;
  reg  [15:0]        ramp_div;       // cycles per ramp step
  wire [7:0]         ramp_level;
  wire               ramp_busy;
  wire               met_square;
  wire               met_enable;
  reg                aw_held;        // write address captured
  reg                w_held;         // write data captured
  reg  [5:0]         wr_addr;
  reg  [31:0]        wr_data;
  reg  [3:0]         wr_strb;
  reg  [31:0]        rd_word;
  wire               do_write;
  wire               ar_take;
  integer            i;

  assign pin_mode = mode_decode(POWERDOWN_N, CTRL_BIT0_TTX_ENABLE,
                                CTRL_BIT1_ACTIVE_SELECT);
  assign do_write = aw_held && w_held && !S_AXI_BVALID;
  assign ar_take  = S_AXI_ARVALID && S_AXI_ARREADY;

  // overload overrides the pins; the pins keep being decoded meanwhile,
  // so recovery lands on whatever mode is selected at that moment
  always @*
  begin
    if (THERMAL_OVERLOAD)
      next_mode = `MODE_DOWN;
    else
      next_mode = pin_mode;
  end

  // detect condition per mode; power down never reports anything
  always @*
  begin
    case (next_mode)
      `MODE_HIZ:  next_detect = OFF_HOOK_SENSE;
      `MODE_ACT:  next_detect = OFF_HOOK_SENSE;
      `MODE_RING: next_detect = RING_TRIP_SENSE;
      default:    next_detect = 1'b0;
    endcase
  end

  // mode register and line stage controls
  always @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      mode                <= `MODE_DOWN;
      overload            <= 1'b0;
      detect              <= 1'b0;
      LINE_HIGH_Z         <= 1'b1;
      DETECT_ENABLE       <= 1'b0;
      HIGH_IMPEDANCE_FEED <= 1'b0;
      DC_FEED_ENABLE      <= 1'b0;
      TX_ENABLE           <= 1'b0;
      FEEDBACK_ENABLE     <= 1'b0;
      VOLTAGE_BUFFER_MODE <= 1'b0;
      RX_GAIN_PLUS6       <= 1'b0;
      TX_GAIN_MINUS12     <= 1'b0;
      ZSCALE_X25          <= 1'b0;
      LOOP_DETECT_N_O     <= 1'b0;
      LOOP_DETECT_N_OE    <= 1'b0;
    end
    else
    begin
      mode                <= next_mode;
      overload            <= THERMAL_OVERLOAD;
      detect              <= next_detect;
      LINE_HIGH_Z         <= (next_mode == `MODE_DOWN);
      DETECT_ENABLE       <= (next_mode != `MODE_DOWN);
      HIGH_IMPEDANCE_FEED <= (next_mode == `MODE_HIZ);
      DC_FEED_ENABLE      <= (next_mode == `MODE_ACT);
      TX_ENABLE           <= (next_mode == `MODE_ACT);
      FEEDBACK_ENABLE     <= (next_mode == `MODE_ACT) ||
                             (next_mode == `MODE_HIZ);
      VOLTAGE_BUFFER_MODE <= (next_mode == `MODE_RING);
      // gain set only matters in active mode
      RX_GAIN_PLUS6       <= (next_mode == `MODE_ACT) && GAIN_SELECT;
      TX_GAIN_MINUS12     <= (next_mode == `MODE_ACT) && GAIN_SELECT;
      ZSCALE_X25          <= (next_mode == `MODE_ACT) && GAIN_SELECT;
      // pin only ever pulled low; the external pull-up gives the high
      LOOP_DETECT_N_O     <= 1'b0;
      LOOP_DETECT_N_OE    <= next_detect;
    end
  end

  // polarity follows bit2 in every mode; ringing comes from its toggling
  polarity_ramp u_ramp
  (
    .clk     (MCLK),
    .resetn  (RESETN),
    .target  (CTRL_BIT2_POLARITY),
    .divider (ramp_div),
    .level   (ramp_level),
    .busy    (ramp_busy)
  );

  metering_gate u_meter
  (
    .clk    (MCLK),
    .resetn (RESETN),
    .tone   (METERING_TONE_CLOCK),
    .active (mode == `MODE_ACT),
    .burst  (CTRL_BIT0_TTX_ENABLE),
    .square (met_square),
    .enable (met_enable)
  );

  // retime submodule results so top outputs stay flop-driven
  always @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      POLARITY_LEVEL         <= `RAMP_MIN;
      METERING_ENABLE        <= 1'b0;
      SHAPED_METERING_SQUARE <= 1'b0;
    end
    else
    begin
      POLARITY_LEVEL         <= ramp_level;
      METERING_ENABLE        <= met_enable;
      SHAPED_METERING_SQUARE <= met_square;
    end
  end

  // event detection from registered flags
  always @*
  begin
    events                  = {`EV_W{1'b0}};
    events[`EV_OFFHOOK]     = next_detect && !detect &&
                              (next_mode != `MODE_RING);
    events[`EV_RINGTRIP]    = next_detect && !detect &&
                              (next_mode == `MODE_RING);
    events[`EV_OVL_SET]     = THERMAL_OVERLOAD && !overload;
    events[`EV_OVL_CLR]     = !THERMAL_OVERLOAD && overload;
    events[`EV_LOOP_RELEASE] = !next_detect && detect;
    // a new event in the clearing cycle survives the clear
    next_int = (int_status & ~int_clear) | events;
  end

  // sticky status, level interrupt one cycle behind the status
  always @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      int_status <= {`EV_W{1'b0}};
      INTERRUPT  <= 1'b0;
    end
    else
    begin
      int_status <= next_int;
      INTERRUPT  <= |(int_status & int_enable);
    end
  end

  // write channels: address and data captured independently
  always @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      wr_addr       <= 6'h00;
      wr_data       <= 32'h00000000;
      wr_strb       <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `RESP_OKAY;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_held       <= 1'b1;
        wr_addr       <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_held       <= 1'b1;
        wr_data      <= S_AXI_WDATA;
        wr_strb      <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (do_write)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        // unmapped offsets answer with a slave error
        S_AXI_BRESP  <= is_mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
      begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // register writes; the clear register only ever produces a pulse
  always @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      int_enable <= {`EV_W{1'b0}};
      int_clear  <= {`EV_W{1'b0}};
      ramp_div   <= RAMP_DIV_RST_C;
    end
    else
    begin
      int_clear <= {`EV_W{1'b0}};
      if (do_write && wr_strb[0])
      begin
        if (wr_addr == `OFF_INT_ENABLE)
          int_enable <= wr_data[`EV_W-1:0];
        if (wr_addr == `OFF_INT_CLEAR)
          int_clear <= wr_data[`EV_W-1:0];
      end
      if (do_write && wr_addr == `OFF_RAMP_CTRL)
      begin
        for (i = 0; i < 2; i = i + 1)
          if (wr_strb[i])
            ramp_div[i*8 +: 8] <= wr_data[i*8 +: 8];
      end
    end
  end

  // read data mux; unused bits read as zero
  always @*
  begin
    rd_word = 32'h00000000;
    case (S_AXI_ARADDR)
      `OFF_STATUS:
      begin
        rd_word[`ST_MODE_MSB:`ST_MODE_LSB] = mode;
        rd_word[`ST_OVERLOAD]  = overload;
        rd_word[`ST_DETECT]    = detect;
        rd_word[`ST_RAMP_BUSY] = ramp_busy;
        rd_word[`ST_REVERSED]  = (ramp_level == `RAMP_MAX);
        rd_word[`ST_METERING]  = met_enable;
        rd_word[`ST_PIN_LEVEL] = LOOP_DETECT_N_I;
      end
      `OFF_INT_STATUS: rd_word[`EV_W-1:0] = int_status;
      `OFF_INT_ENABLE: rd_word[`EV_W-1:0] = int_enable;
      `OFF_RAMP_CTRL:  rd_word[15:0]      = ramp_div;
      default:         rd_word            = 32'h00000000;
    endcase
  end

  // read channel: one read outstanding, answer the cycle after taking it
  always @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= `RESP_OKAY;
    end
    else if (ar_take)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= rd_word;
      S_AXI_RRESP   <= is_mapped(S_AXI_ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

endmodule

// ===== shared/line_mode_ctrl_map.vh
`ifndef LINE_MODE_CTRL_MAP_VH
`define LINE_MODE_CTRL_MAP_VH

// register byte offsets on the AXI4-Lite slave
`define OFF_STATUS       6'h00
`define OFF_INT_STATUS   6'h04
`define OFF_INT_ENABLE   6'h08
`define OFF_INT_CLEAR    6'h0C
`define OFF_RAMP_CTRL    6'h10

// status register fields
`define ST_MODE_LSB      0
`define ST_MODE_MSB      3
`define ST_OVERLOAD      4
`define ST_DETECT        5
`define ST_RAMP_BUSY     6
`define ST_REVERSED      7
`define ST_METERING      8
`define ST_PIN_LEVEL     9

// event bits shared by status, enable and clear registers
`define EV_W             5
`define EV_OFFHOOK       0
`define EV_RINGTRIP      1
`define EV_OVL_SET       2
`define EV_OVL_CLR       3
`define EV_LOOP_RELEASE  4

// one-hot operating modes
`define MODE_DOWN        4'h1
`define MODE_HIZ         4'h2
`define MODE_ACT         4'h4
`define MODE_RING        4'h8

// bus responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

// polarity ramp timing
`define CLK_PERIOD_NS    4
`define RAMP_STEP_NS     100
`define RAMP_DIV_RST     ((`RAMP_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RAMP_MAX         8'hFF
`define RAMP_MIN         8'h00

`endif

// ===== rtl/polarity_ramp.v
`include "line_mode_ctrl_map.vh"

// soft polarity transition: level walks one step per divider period
module polarity_ramp
(
  input  wire        clk,
  input  wire        resetn,
  input  wire        target,
  input  wire [15:0] divider,
  output reg  [7:0]  level,
  output reg         busy
);

  reg [15:0] tick_cnt;   // prescaler for the ramp steps
  wire       tick;       // one step is due
  wire       at_goal;    // level already at the commanded end

  assign tick    = (tick_cnt == 16'h0000);
  assign at_goal = target ? (level == `RAMP_MAX) : (level == `RAMP_MIN);

  // prescaler reloads the programmed divider minus one each step
  always @(posedge clk)
  begin
    if (!resetn)
      tick_cnt <= 16'h0000;
    else if (tick)
      tick_cnt <= (divider == 16'h0000) ? 16'h0000 : divider - 16'h0001;
    else
      tick_cnt <= tick_cnt - 16'h0001;
  end

  // ramp instead of step, so a reversal never hits the line abruptly
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      level <= `RAMP_MIN;
      busy  <= 1'b0;
    end
    else
    begin
      busy <= !at_goal;
      if (tick && !at_goal)
      begin
        if (target)
          level <= level + 8'h01;
        else
          level <= level - 8'h01;
      end
    end
  end

endmodule

// ===== rtl/metering_gate.v
`include "line_mode_ctrl_map.vh"

// burst gate for the metering square wave
module metering_gate
(
  input  wire clk,
  input  wire resetn,
  input  wire tone,
  input  wire active,
  input  wire burst,
  output reg  square,
  output reg  enable
);

  // the burst length is exactly the time bit0 stays high in active mode;
  // a tone clock that stops early simply freezes the square output
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      square <= 1'b0;
      enable <= 1'b0;
    end
    else
    begin
      enable <= active & burst;
      square <= active & burst & tone;
    end
  end

endmodule

// ===== tb/line_mode_ctrl_checker.sv
// watches the mode pins against the line stage outputs of the block
module line_mode_ctrl_checker
(
  input wire       MCLK,
  input wire       RESETN,
  input wire       POWERDOWN_N,
  input wire       CTRL_BIT0_TTX_ENABLE,
  input wire       CTRL_BIT1_ACTIVE_SELECT,
  input wire       GAIN_SELECT,
  input wire       THERMAL_OVERLOAD,
  input wire       OFF_HOOK_SENSE,
  input wire       RING_TRIP_SENSE,
  input wire       LOOP_DETECT_N_OE,
  input wire       LINE_HIGH_Z,
  input wire       DETECT_ENABLE,
  input wire       TX_ENABLE,
  input wire       FEEDBACK_ENABLE,
  input wire       VOLTAGE_BUFFER_MODE,
  input wire       RX_GAIN_PLUS6,
  input wire [7:0] POLARITY_LEVEL,
  input wire       METERING_ENABLE
);
  timeunit 1ns;
  timeprecision 1ps;
  // applied modes: overload beats whatever the pins ask for
  wire up = POWERDOWN_N & ~THERMAL_OVERLOAD;
  wire act = up & CTRL_BIT1_ACTIVE_SELECT;
  wire idle = ~CTRL_BIT0_TTX_ENABLE & ~CTRL_BIT1_ACTIVE_SELECT;
  wire ring = up & CTRL_BIT0_TTX_ENABLE & ~CTRL_BIT1_ACTIVE_SELECT;
  wire hiz = up & idle;

  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);

  a_down_line_off: assert property (!POWERDOWN_N |=> LINE_HIGH_Z
    && !DETECT_ENABLE && !LOOP_DETECT_N_OE) else $error("pd not off");
  a_ovl_forces_pd: assert property (THERMAL_OVERLOAD |=> LINE_HIGH_Z
    && !TX_ENABLE) else $error("overload did not force pd");
  a_ovl_recovery: assert property ($fell(THERMAL_OVERLOAD) && act
    |=> TX_ENABLE && !LINE_HIGH_Z) else $error("no mode after overload");
  a_hiz_offhook: assert property (hiz && OFF_HOOK_SENSE
    |=> LOOP_DETECT_N_OE) else $error("hiz off-hook not reported");
  a_tx_only_act: assert property (!act |=> !TX_ENABLE)
    else $error("tx outside active");
  a_gain_follow: assert property (act
    |=> RX_GAIN_PLUS6 == $past(GAIN_SELECT)) else $error("gain wrong");
  // gate sees the registered mode but the live burst bit: mode lags one more
  a_meter_off: assert property (!CTRL_BIT0_TTX_ENABLE
    |-> ##2 !METERING_ENABLE) else $error("metering without burst");
  a_meter_mode: assert property (!act
    |-> ##3 !METERING_ENABLE) else $error("metering outside active");
  a_meter_on: assert property (act && CTRL_BIT0_TTX_ENABLE
    ##1 act && CTRL_BIT0_TTX_ENABLE
    |-> ##2 METERING_ENABLE) else $error("metering missing");
  a_ring_buffer: assert property (ring |=> VOLTAGE_BUFFER_MODE
    && !FEEDBACK_ENABLE) else $error("ring loops not off");
  a_ring_trip: assert property (ring && RING_TRIP_SENSE
    |=> LOOP_DETECT_N_OE) else $error("ring trip not reported");
  // a ramp never jumps: one step at a time in either direction
  a_ramp_step: assert property ($changed(POLARITY_LEVEL)
    |-> 8'(POLARITY_LEVEL - $past(POLARITY_LEVEL)) inside {8'h01, 8'hFF})
    else $error("polarity stepped");
endmodule

bind line_mode_ctrl line_mode_ctrl_checker line_mode_ctrl_checker_inst (
  .MCLK(MCLK), .RESETN(RESETN), .POWERDOWN_N(POWERDOWN_N),
  .CTRL_BIT0_TTX_ENABLE(CTRL_BIT0_TTX_ENABLE),
  .CTRL_BIT1_ACTIVE_SELECT(CTRL_BIT1_ACTIVE_SELECT),
  .GAIN_SELECT(GAIN_SELECT), .THERMAL_OVERLOAD(THERMAL_OVERLOAD),
  .OFF_HOOK_SENSE(OFF_HOOK_SENSE), .RING_TRIP_SENSE(RING_TRIP_SENSE),
  .LOOP_DETECT_N_OE(LOOP_DETECT_N_OE), .LINE_HIGH_Z(LINE_HIGH_Z),
  .DETECT_ENABLE(DETECT_ENABLE), .TX_ENABLE(TX_ENABLE),
  .FEEDBACK_ENABLE(FEEDBACK_ENABLE),
  .VOLTAGE_BUFFER_MODE(VOLTAGE_BUFFER_MODE), .RX_GAIN_PLUS6(RX_GAIN_PLUS6),
  .POLARITY_LEVEL(POLARITY_LEVEL), .METERING_ENABLE(METERING_ENABLE)
);

// ===== tb/card_controller_model.sv
// card controller: turns a commanded mode into the parallel mode pins
module card_controller_model
#(
  parameter int RING_HALF = 150,  // cycles between ring polarity toggles
  parameter int TONE_HALF = 5     // half period of the metering tone
)
(
  input  wire logic       clk,
  input  wire logic [1:0] sel,    // 0 pd, 1 hiz, 2 active, 3 ring
  input  wire logic       ttx,    // metering burst request in active
  input  wire logic       pol,    // polarity request outside ring
  input  wire logic       loop_n, // resolved detect pin
  output logic            pwr_n = 1'b0,
  output logic            bit0 = 1'b0,
  output logic            bit1 = 1'b0,
  output logic            bit2 = 1'b0,
  output logic            tone = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  int rc = 0;  // ring half-period counter
  int tc = 0;  // tone half-period counter

  // pins change only just after an edge, like real controller logic
  always @(posedge clk)
  begin
    pwr_n <= (sel != 2'd0);
    bit1 <= (sel == 2'd2);
    bit0 <= (sel == 2'd3) | ((sel == 2'd2) & ttx);
    // tone runs free so it covers every burst edge to edge
    tc <= (tc == TONE_HALF - 1) ? 0 : tc + 1;
    if (tc == TONE_HALF - 1)
      tone <= ~tone;
    if (sel != 2'd3)
    begin
      bit2 <= pol;
      rc <= 0;
    end
    // ring trip seen: hold the polarity so the ring signal stops
    else if (loop_n)
    begin
      rc <= (rc == RING_HALF - 1) ? 0 : rc + 1;
      if (rc == RING_HALF - 1)
        bit2 <= ~bit2;
    end
  end
endmodule

// ===== tb/line_mode_ctrl_test.sv
// directed bench: controller model drives the pins, tasks drive the bus
module line_mode_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rstn = 1'b0, ttx = 1'b0, pol = 1'b0, gsel = 1'b0;
  logic thm = 1'b0, ohk = 1'b0, rtr = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [1:0] sel = 2'd0, rs;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h00000000, rd;
  wire pwr_n, b0, b1, b2, tone, loop_o, loop_oe, lhz, den, hif, dcf, txe;
  wire fbe, msq;
  wire vbm, rxg, txg, zsc, men, irq, awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [7:0] pl;
  wire [31:0] rdata;
  wire loop_pin = loop_oe ? loop_o : 1'b1; // pulled-up open drain
  int n_mismatch = 0, n_checks = 0;

  always #2 clk = ~clk;

  line_mode_ctrl line_mode_ctrl_inst (
    .MCLK(clk), .RESETN(rstn), .POWERDOWN_N(pwr_n),
    .CTRL_BIT0_TTX_ENABLE(b0), .CTRL_BIT1_ACTIVE_SELECT(b1),
    .CTRL_BIT2_POLARITY(b2), .GAIN_SELECT(gsel), .METERING_TONE_CLOCK(tone),
    .THERMAL_OVERLOAD(thm), .OFF_HOOK_SENSE(ohk), .RING_TRIP_SENSE(rtr),
    .LOOP_DETECT_N_I(loop_pin), .LOOP_DETECT_N_O(loop_o),
    .LOOP_DETECT_N_OE(loop_oe), .LINE_HIGH_Z(lhz), .DETECT_ENABLE(den),
    .HIGH_IMPEDANCE_FEED(hif), .DC_FEED_ENABLE(dcf), .TX_ENABLE(txe),
    .FEEDBACK_ENABLE(fbe), .VOLTAGE_BUFFER_MODE(vbm), .RX_GAIN_PLUS6(rxg),
    .TX_GAIN_MINUS12(txg), .ZSCALE_X25(zsc), .POLARITY_LEVEL(pl),
    .METERING_ENABLE(men), .SHAPED_METERING_SQUARE(msq), .INTERRUPT(irq),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  card_controller_model card_controller_model_inst (.clk(clk), .sel(sel),
    .ttx(ttx), .pol(pol), .loop_n(loop_pin), .pwr_n(pwr_n), .bit0(b0),
    .bit1(b1), .bit2(b2), .tone(tone));

  // one comparison, counted; unknowns never match
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // command a mode, then let controller and block settle
  task automatic go(input logic [1:0] m, input int n);
    sel <= m;
    repeat (n) @(posedge clk);
  endtask

  // bus write: each channel released at its own handshake edge
  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask

  // bus read: address held until taken, data taken at the rvalid edge
  task automatic rdw(input logic [5:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic t_power_down();
    ohk <= 1'b1;
    go(2'd0, 6);
    chk("high_z", lhz, 1);
    chk("detect_en", den, 0);
    chk("detect_pin", loop_pin, 1);
    chk("tx_pd", txe, 0);
    chk("square_pd", msq, 0);
    ohk <= 1'b0;
    $display("test power_down done");
  endtask

  // off-hook in hiz raises the interrupt, then mask, clear, bad address
  task automatic t_hiz_irq();
    wr(6'h08, 32'h00000001, rs);
    go(2'd1, 6);
    chk("hiz_feed", hif, 1);
    chk("tx_hiz", txe, 0);
    ohk <= 1'b1;
    repeat (4) @(posedge clk);
    chk("offhook_pin", loop_pin, 0);
    chk("irq_on", irq, 1);
    rdw(6'h04, rd, rs);
    chk("int_status", rd[0], 1);
    wr(6'h08, 32'h00000000, rs);
    repeat (2) @(posedge clk);
    chk("irq_masked", irq, 0);
    wr(6'h0C, 32'h00000001, rs);
    repeat (2) @(posedge clk);
    rdw(6'h04, rd, rs);
    chk("int_cleared", rd[0], 0);
    wr(6'h3C, 32'h00000001, rs);
    chk("bresp_bad", rs, 2);
    rdw(6'h3C, rd, rs);
    chk("rresp_bad", rs, 2);
    ohk <= 1'b0;
    $display("test hiz_irq done");
  endtask

  // every active substate and gain set, then a ramp back down to zero and a full polarity ramp up
  task automatic t_active();
    int i;
    rdw(6'h10, rd, rs);
    chk("ramp_rst", rd, 32'h00000019);
    wr(6'h10, 32'h00000001, rs);
    for (i = 0; i < 8; i++)
    begin
      ttx <= i[0];
      pol <= i[1];
      gsel <= i[2];
      go(2'd2, 8);
      chk("tx_act", txe, 1);
      chk("dc_feed", dcf, 1);
      chk("metering", men, i[0]);
      chk("gain", {rxg, txg, zsc}, {3{i[2]}});
    end
    rdw(6'h00, rd, rs);
    chk("status_mode", rd[3:0], 4'h4);
    ttx <= 1'b0;
    for (i = 0; i < 2; i++)
    begin
      pol <= ~pol;
      repeat (10) @(posedge clk);
      chk("ramp_mid", pl != 8'h00 && pl != 8'hFF, 1);
      repeat (600) @(posedge clk);
      chk("ramp_end", pl, pol ? 8'hFF : 8'h00);
    end
    $display("test active done");
  endtask

  // overload forces pd; pins move meanwhile and apply on recovery
  task automatic t_overload();
    logic [1:0] sq;
    ttx <= 1'b0;
    gsel <= 1'b0;
    go(2'd2, 6);
    thm <= 1'b1;
    repeat (4) @(posedge clk);
    chk("ovl_high_z", lhz, 1);
    chk("ovl_tx", txe, 0);
    gsel <= 1'b1;
    ttx <= 1'b1;
    repeat (4) @(posedge clk);
    thm <= 1'b0;
    repeat (4) @(posedge clk);
    chk("rec_tx", txe, 1);
    chk("rec_gain", rxg, 1);
    chk("rec_meter", men, 1);
    // a tone half period is 5 cycles, so 10 cycles must show both levels
    sq = 2'b00;
    repeat (10)
    begin
      @(posedge clk);
      sq = sq | {msq, ~msq};
    end
    chk("square", sq, 2'b11);
    $display("test overload done");
  endtask

  // ringing toggles polarity until ring trip, then back to active
  task automatic t_ringing();
    ttx <= 1'b0;
    go(2'd3, 400);
    chk("buffer_mode", vbm, 1);
    chk("feedback", fbe, 0);
    chk("ring_ramp", pl != 8'h00, 1);
    rtr <= 1'b1;
    repeat (4) @(posedge clk);
    chk("trip_pin", loop_pin, 0);
    rtr <= 1'b0;
    go(2'd2, 6);
    chk("after_ring", txe, 1);
    $display("test ringing done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog: the tests need about 1800 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_power_down();
    t_hiz_irq();
    t_active();
    t_overload();
    t_ringing();
    end_of_test();
  end
endmodule
